// File: src/seb_cfg.svh
// Purpose: shared constants of the strobed expansion bus
// Assumes: 100 MHz clk_sys on both ends
// Notes:   op codes are the three select lines, read as {line3,line2,line1}
`ifndef SEB_CFG_SVH
`define SEB_CFG_SVH
`define SEB_OFS_READ_PRIMARY   8'hC0
`define SEB_OFS_READ_SECONDARY 8'hC2
`define SEB_OFS_READ_SPARE     8'hC4
`define SEB_OFS_BUS_RESET      8'hC6
`define SEB_OFS_ADDR_FIRST     8'hC8
`define SEB_OFS_ADDR_SECOND    8'hCA
`define SEB_OFS_ADDR_THIRD     8'hCC
`define SEB_OFS_WRITE_PORT     8'hCE
`define SEB_STROBE_NS          40
`define SEB_CLK_NS             10
`define SEB_STROBE_CYC         ((`SEB_STROBE_NS + `SEB_CLK_NS - 1) / `SEB_CLK_NS)
// host waits this long after the strobe rises, until the device has let go of the data lines
`define SEB_TURN_CYC           3
`define SEB_CAT_LSB            0
`define SEB_CAT_MSB            3
`define SEB_PRESENT_BIT        0
`endif

// File: src/seb_pkg.sv
// Purpose: types of the strobed expansion bus
// Assumes: nothing
// Notes:   op enum values are the select-line codes
package seb_pkg;
   typedef enum logic [2:0] {
      SEB_OP_READ_PRIMARY   = 3'h0,
      SEB_OP_READ_SECONDARY = 3'h1,
      SEB_OP_READ_SPARE     = 3'h2,
      SEB_OP_BUS_RESET      = 3'h3,
      SEB_OP_ADDR_FIRST     = 3'h4,
      SEB_OP_ADDR_SECOND    = 3'h5,
      SEB_OP_ADDR_THIRD     = 3'h6,
      SEB_OP_DATA_WRITE     = 3'h7
   } seb_op_t;
   typedef enum logic [1:0] {
      SEB_H_IDLE   = 2'b00,
      SEB_H_SETUP  = 2'b01,
      SEB_H_STROBE = 2'b11,
      SEB_H_HOLD   = 2'b10
   } seb_hstate_t;
endpackage

// File: src/seb_bus_if.sv
// Purpose: wires of the strobed expansion bus between host and one device
// Assumes: data lines and attention resolve from the enables
// Notes:   released lines read high (pull-ups)
interface seb_bus_if;
   logic       bus_strobe_n;
   logic [2:0] operation_select_lines;
   logic [7:0] host_data_out;
   logic       host_data_oe;
   logic [7:0] dev_data_out;
   logic       dev_data_oe;
   logic       attention_n_oe;
   logic [7:0] data_lines;
   logic       attention_n;
   assign data_lines  = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 8'hFF);
   assign attention_n = attention_n_oe ? 1'b0 : 1'b1;
   modport host (output bus_strobe_n, output operation_select_lines, output host_data_out,
                 output host_data_oe, input data_lines, input attention_n);
   modport device (input bus_strobe_n, input operation_select_lines, input data_lines,
                   output dev_data_out, output dev_data_oe, output attention_n_oe);
endinterface

// File: src/seb_addr_match.sv
// Purpose: compare one address cycle against the device address for its category
// Assumes: category taken from the low nibble of the first address byte
// Notes:   purely combinational
module seb_addr_match
   import seb_pkg::*;
(
   // cycle
   input  wire logic [1:0] cycle_idx,
   input  wire logic [7:0] cycle_data,
   input  wire logic [3:0] category,
   // own address
   input  wire logic [7:0] own_addr [3],
   // result
   output logic            hit,
   output logic [1:0]      cycles_needed,
   output logic [7:0]      width_mask
);
   function automatic logic [7:0] mask_for(input logic [3:0] c);
      if (c <= 4'h2 || c == 4'hB) mask_for = 8'h0F;
      else if (c <= 4'h7) mask_for = 8'h1F;
      else if (c <= 4'hA) mask_for = 8'h3F;
      else mask_for = 8'hFF;
   endfunction
   function automatic logic [1:0] count_for(input logic [3:0] c);
      if (c == 4'hA || c == 4'hB || c == 4'hE || c == 4'hF) count_for = 2'd1;
      else if (c == 4'hC) count_for = 2'd2;
      else if (c == 4'h3) count_for = 2'd0;
      else count_for = 2'd3;
   endfunction
   wire logic [7:0] cyc_mask = (cycle_idx == 2'd0) ? mask_for(cycle_data[3:0]) : mask_for(category);
   assign width_mask    = mask_for(category);
   assign cycles_needed = count_for(category);
   assign hit           = ((cycle_data & cyc_mask) == (own_addr[cycle_idx] & cyc_mask));
endmodule // seb_addr_match

// File: src/seb_device.sv
// Purpose: device end of the strobed expansion bus
// Assumes: bus pins are asynchronous to clk_sys and pass two flip-flops
//          service_request and the read bytes already run on clk_sys
// Notes:   an operation takes effect on the falling strobe edge
//          every bus event reaches the logic three clocks late, so read data
//          stays on the lines for three clocks after the strobe rises; the host
//          waits that long before it drives the lines again
//          a second address cycle clears the third latch
//          category 0011 names no width and never selects
//          4-bit categories drive the high data lines high, as if released
//
// How it works
// R1: select lines pick one of eight operations
// R2: code 011 read is bus reset
// R3: codes 100,101,110 are address cycles
// R4: selected device serves reads and writes
// R5: first latch set on matching first cycle
// R6: second latch needs first plus match
// R7: third latch needs first two plus match
// R8: host sends address cycles in order
// R9: first byte low nibble is category
// R10: categories 0-2: three 4-bit cycles
// R11: categories 4-7: three 5-bit cycles
// R12: 8,9 three 6-bit; A single 6-bit
// R13: category 1011 is the expansion register
// R14: C two bytes, D three, E/F one
// R15: 4-bit ops use low lines only
// R16: operation happens on falling strobe
// R17: low attention line requests service
// R18: foreign categories are ignored
// R19: no minimum spacing between accesses
// R20: selection never disturbs internal operation
// R21: present 4-bit device pulls bit 0 low
// R22: reset or first mismatch clears latches
// R23: drive data only on selected reads
`include "seb_cfg.svh"
module seb_device
   import seb_pkg::*;
#(
   parameter logic [7:0] ADDR_FIRST  = 8'h0D,
   parameter logic [7:0] ADDR_SECOND = 8'h12,
   parameter logic [7:0] ADDR_THIRD  = 8'h34
)(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // bus
   seb_bus_if.device       bus,
   // user side
   input  wire logic [7:0] read_primary_data,
   input  wire logic [7:0] read_spare_data,
   input  wire logic       service_request,
   output logic [7:0]      write_data,
   output logic            write_strobe,
   output logic            selected,
   output logic            bus_reset_seen
);
   logic [1:0]  strb_sync;
   logic [2:0]  op_s1, op_s2;
   logic [7:0]  dat_s1, dat_s2;
   logic        strb_prev;
   logic [2:0]  latch;
   logic [3:0]  category;
   logic [7:0]  dev_out;
   logic        dev_oe;
   logic        in_read;

   // 011 is bus reset, so only three codes are answered reads
   function automatic logic answers_read(input seb_op_t o);
      answers_read = (o == SEB_OP_READ_PRIMARY) || (o == SEB_OP_READ_SECONDARY) ||
                     (o == SEB_OP_READ_SPARE);
   endfunction

   // cut a byte to the width in use; pad fills the unused lines high as released lines read
   function automatic logic [7:0] to_width(input logic [7:0] d, input logic [7:0] m, input logic pad);
      to_width = (d & m) | (pad ? ~m : 8'h00);
   endfunction

   wire logic [7:0] own_addr [3];
   assign own_addr[0] = ADDR_FIRST;
   assign own_addr[1] = ADDR_SECOND;
   assign own_addr[2] = ADDR_THIRD;

   // two-stage synchronisers on every bus input
   // select and data lines settle before the strobe falls, so equal depth keeps them in step
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         strb_sync <= 2'b11;
         op_s1     <= 3'h0;
         op_s2     <= 3'h0;
         dat_s1    <= 8'h00;
         dat_s2    <= 8'h00;
      end else begin
         strb_sync <= {strb_sync[0], bus.bus_strobe_n};
         op_s1     <= bus.operation_select_lines;
         op_s2     <= op_s1;
         dat_s1    <= bus.data_lines;
         dat_s2    <= dat_s1;
      end
   end

   // R16: falling strobe edge
   // R19: no spacing assumed
   wire logic      strobe_fall = strb_prev & ~strb_sync[1];
   wire logic      strobe_low  = ~strb_sync[1];
   // R1: decode the three select lines
   wire seb_op_t   op          = seb_op_t'(op_s2);
   // R3: address cycle decode
   wire logic      is_adr0     = strobe_fall && op == SEB_OP_ADDR_FIRST;
   wire logic      is_adr1     = strobe_fall && op == SEB_OP_ADDR_SECOND;
   wire logic      is_adr2     = strobe_fall && op == SEB_OP_ADDR_THIRD;
   // R2: read with code 011 is bus reset
   wire logic      is_reset    = strobe_fall && op == SEB_OP_BUS_RESET;
   wire logic      is_write    = strobe_fall && op == SEB_OP_DATA_WRITE;
   // own address byte that this cycle is held against
   wire logic [1:0] cyc_idx    = (op == SEB_OP_ADDR_FIRST) ? 2'd0 : (op == SEB_OP_ADDR_SECOND) ? 2'd1 : 2'd2;

   // per-cycle compare against the own address
   logic       hit;
   logic [1:0] need;
   logic [7:0] wmask;
   // R9: category from first byte low nibble
   seb_addr_match u_match (
      .cycle_idx     (cyc_idx),
      .cycle_data    (dat_s2),
      .category      (category),
      .own_addr      (own_addr),
      .hit           (hit),
      .cycles_needed (need),
      .width_mask    (wmask)
   );

   // our own category is the low nibble of the first address byte
   wire logic [3:0] own_cat  = ADDR_FIRST[`SEB_CAT_MSB:`SEB_CAT_LSB];
   // a set first latch means the latched category is our own, so need is our count
   // R10: R11: R12: R13: R14: full selection after the category's cycle count
   wire logic full_sel = (need == 2'd0) ? 1'b0 :
                         (need == 2'd1) ? latch[0] :
                         (need == 2'd2) ? (latch[0] & latch[1]) : (&latch);
   // R18: a first cycle of another category never matches
   wire logic first_hit = hit && (dat_s2[3:0] == own_cat);

   // selection latches and the category they were set under
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         strb_prev <= 1'b1;
         latch     <= 3'b000;
         category  <= 4'h0;
      end else begin
         strb_prev <= strb_sync[1];
         // R22: clear on bus reset
         if (is_reset) begin
            latch <= 3'b000;
         end else if (is_adr0) begin
            // R5: R22: first latch, cleared on mismatch
            category <= dat_s2[3:0];
            latch    <= {2'b00, first_hit};
         end else if (is_adr1 && need >= 2'd2) begin
            // R6: second latch follows the first
            latch[1] <= latch[0] & hit;
            latch[2] <= 1'b0;
         end else if (is_adr2 && need == 2'd3) begin
            // R7: third latch follows the first two
            latch[2] <= latch[0] & latch[1] & hit;
         end
      end
   end

   // R4: R15: R21: R23: read data driven only when selected
   wire logic is_read    = strobe_low && answers_read(op);
   wire logic read_start = is_read && !in_read;
   wire logic [7:0] sec = {read_primary_data[7:1], 1'b0};
   wire logic [7:0] rd_mux = (op == SEB_OP_READ_PRIMARY) ? read_primary_data :
                             (op == SEB_OP_READ_SECONDARY) ? sec : read_spare_data;
   // R13: expansion register is four bits wide
   wire logic [7:0] ext_mask = (own_cat == 4'hB) ? 8'h0F : wmask;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dev_out        <= 8'h00;
         dev_oe         <= 1'b0;
         in_read        <= 1'b0;
         write_data     <= 8'h00;
         write_strobe   <= 1'b0;
         bus_reset_seen <= 1'b0;
      end else begin
         in_read        <= is_read;
         dev_oe         <= is_read && full_sel;
         // the byte is frozen at the start of a read so the lines hold still under the strobe
         if (read_start) begin
            dev_out <= to_width(rd_mux, ext_mask, 1'b1);
         end
         // R4: R20: write served only when selected, internal state untouched by selection
         write_strobe   <= is_write && full_sel;
         if (is_write && full_sel) begin
            write_data <= to_width(dat_s2, ext_mask, 1'b0);
         end
         // R2: reported even when not selected
         bus_reset_seen <= is_reset;
      end
   end

   // selection and bus drive
   assign selected         = full_sel;
   assign bus.dev_data_out = dev_out;
   assign bus.dev_data_oe  = dev_oe;
   // R17: open-drain attention
   assign bus.attention_n_oe = service_request;
endmodule // seb_device

// File: src/seb_host.sv
// Purpose: host end of the strobed expansion bus
// Assumes: one request at a time on the user side
// Notes:   each request is one strobed operation
`include "seb_cfg.svh"
module seb_host
   import seb_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // bus
   seb_bus_if.host         bus,
   // user side
   input  wire logic       req_valid,
   input  wire logic [7:0] req_offset,
   input  wire logic [7:0] req_wdata,
   output logic            req_ready,
   output logic            rsp_valid,
   output logic [7:0]      rsp_rdata,
   output logic            irq
);
   seb_hstate_t state;
   logic [3:0]  cnt;
   logic [2:0]  op;
   logic [7:0]  wd;
   logic        is_wr;
   logic [1:0]  at_sync;

   // R1: offset to select-line code
   wire logic [2:0] op_of_ofs = req_offset[3:1];
   wire logic       wr_op     = op_of_ofs[2];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state     <= SEB_H_IDLE;
         cnt       <= 4'h0;
         op        <= 3'h0;
         wd        <= 8'h00;
         is_wr     <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
      end else begin
         rsp_valid <= 1'b0;
         unique case (state)
            SEB_H_IDLE: begin
               if (req_valid) begin
                  op    <= op_of_ofs;
                  wd    <= req_wdata;
                  is_wr <= wr_op;
                  cnt   <= 4'(`SEB_STROBE_CYC);
                  state <= SEB_H_SETUP;
               end
            end
            SEB_H_SETUP: begin
               cnt   <= 4'(`SEB_STROBE_CYC);
               state <= SEB_H_STROBE;
            end
            SEB_H_STROBE: begin
               if (cnt == 4'h0) begin
                  rsp_rdata <= bus.data_lines;
                  cnt       <= 4'(`SEB_TURN_CYC);
                  state     <= SEB_H_HOLD;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            // the device releases the lines only after its synchronisers see the strobe rise
            SEB_H_HOLD: begin
               if (cnt == 4'h0) begin
                  rsp_valid <= 1'b1;
                  state     <= SEB_H_IDLE;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
         endcase
      end
   end

   // R17: attention low is an interrupt
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         at_sync <= 2'b11;
      end else begin
         at_sync <= {at_sync[0], bus.attention_n};
      end
   end

   assign req_ready                  = (state == SEB_H_IDLE);
   assign irq                        = ~at_sync[1];
   // R16: strobe low during the operation
   assign bus.bus_strobe_n           = (state != SEB_H_STROBE);
   assign bus.operation_select_lines = op;
   assign bus.host_data_out          = wd;
   // R8: R15: host drives data only for address and write ops
   assign bus.host_data_oe           = is_wr && state != SEB_H_IDLE;
endmodule // seb_host

// File: tb/seb_bus_checker.sv
// Purpose: concurrent checks on the wires between host and device
// Assumes: one clk_sys domain, synchronous active-high rst
// Notes:   watches the design's drives only
module seb_bus_checker (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   // bus lines
   input wire logic       bus_strobe_n,
   input wire logic [2:0] operation_select_lines,
   input wire logic [7:0] host_data_out,
   input wire logic       host_data_oe,
   input wire logic       dev_data_oe,
   input wire logic       attention_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_no_drive_clash: assert property (!(host_data_oe && dev_data_oe))
      else $error("both ends drive the data lines");
   a_dev_read_only: assert property (dev_data_oe |-> operation_select_lines inside {3'h0, 3'h1, 3'h2})
      else $error("device drives outside a read");
   a_dev_release: assert property ($rose(bus_strobe_n) |-> ##[0:8] !dev_data_oe)
      else $error("device keeps the data lines");
   a_host_write_only: assert property (host_data_oe |-> operation_select_lines[2])
      else $error("host drives data on a read code");
   a_strobe_length: assert property ($fell(bus_strobe_n) |-> !bus_strobe_n [*5] ##1 bus_strobe_n)
      else $error("strobe width wrong");
   a_select_steady: assert property (!bus_strobe_n && !$past(bus_strobe_n) |-> $stable(operation_select_lines))
      else $error("select lines move under strobe");
   a_addr_steady: assert property (!bus_strobe_n && !$past(bus_strobe_n) && host_data_oe |-> $stable(host_data_out))
      else $error("address or data moves under strobe");
   a_idle_after_rst: assert property ($fell(rst) |-> bus_strobe_n && !host_data_oe && !dev_data_oe)
      else $error("bus not idle after reset");
   c_write_op: cover property ($fell(bus_strobe_n) && operation_select_lines == 3'h7);
   c_dev_read: cover property (dev_data_oe);
   c_attention: cover property (attention_n_oe);
endmodule // seb_bus_checker

// File: tb/test_strobed_expansion_bus_slave.sv
// Purpose: random traffic through host and device, checked against a latch model
// Assumes: device address 0D 12 34, an 8-bit three-byte category
// Notes:   address cycles are always sent as whole ordered triples
module test_strobed_expansion_bus_slave
   import seb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 0;
   logic        rst = 1;
   logic        req_valid = 0;
   logic        service_request = 0;
   logic [7:0]  req_offset = 8'h00;
   logic [7:0]  req_wdata = 8'h00;
   logic [7:0]  read_primary_data = 8'h00;
   logic [7:0]  read_spare_data = 8'h00;
   logic        req_ready, rsp_valid, irq, write_strobe, selected, bus_reset_seen;
   logic [7:0]  rsp_rdata, write_data, e;
   logic [31:0] seed = 32'h3A9F;
   logic [7:0]  own [3] = '{8'h0D, 8'h12, 8'h34};
   logic        l1 = 0, l2 = 0, l3 = 0, ws_seen = 0, br_seen = 0;
   int          fails = 0, check_count = 0, i, k;
   seb_bus_if sbus();
   seb_host i_seb_host (.clk_sys, .rst, .bus(sbus), .req_valid, .req_offset, .req_wdata,
      .req_ready, .rsp_valid, .rsp_rdata, .irq);
   seb_device #(.ADDR_FIRST(8'h0D), .ADDR_SECOND(8'h12), .ADDR_THIRD(8'h34)) i_seb_device (
      .clk_sys, .rst, .bus(sbus), .read_primary_data, .read_spare_data, .service_request,
      .write_data, .write_strobe, .selected, .bus_reset_seen);
   seb_bus_checker i_seb_bus_checker (.clk_sys, .rst, .bus_strobe_n(sbus.bus_strobe_n),
      .operation_select_lines(sbus.operation_select_lines), .host_data_out(sbus.host_data_out),
      .host_data_oe(sbus.host_data_oe), .dev_data_oe(sbus.dev_data_oe),
      .attention_n_oe(sbus.attention_n_oe));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // pulses are caught between compares
   always @(posedge clk_sys) begin
      if (write_strobe === 1'b1) ws_seen <= 1;
      if (bus_reset_seen === 1'b1) br_seen <= 1;
   end
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
   endfunction
   task automatic give_verdict;
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask
   task automatic op(input logic [7:0] ofs, input logic [7:0] wd);
      int n;
      logic [7:0] got;
      chk("req_ready", 8'h01, {7'h00, req_ready});
      ws_seen = 0;
      br_seen = 0;
      req_offset = ofs;
      req_wdata = wd;
      req_valid = 1;
      @(posedge clk_sys);
      #1 req_valid = 0;
      chk("req_ready", 8'h00, {7'h00, req_ready});
      n = 0;
      while (rsp_valid !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n == 50) begin
         fails++;
         give_verdict;
      end
      got = rsp_rdata;
      // the next request follows at once: only the host's turnaround keeps the drivers apart
      e = 8'hFF;
      if (l3 && ofs == 8'hC0) e = read_primary_data;
      if (l3 && ofs == 8'hC2) e = {read_primary_data[7:1], 1'b0};
      if (l3 && ofs == 8'hC4) e = read_spare_data;
      if (!ofs[3]) chk("rdata", e, got);
      case (ofs)
         8'hC8: {l1, l2, l3} = {wd == 8'h0D, 2'b00};
         8'hCA: {l2, l3} = {l1 && wd == 8'h12, 1'b0};
         8'hCC: l3 = l1 && l2 && wd == 8'h34;
         8'hC6: {l1, l2, l3} = 3'b000;
         default: ;
      endcase
      chk("write_strobe", {7'h00, ofs == 8'hCE && l3}, {7'h00, ws_seen});
      if (ofs == 8'hCE && l3) chk("write_data", wd, write_data);
      chk("bus_reset_seen", {7'h00, ofs == 8'hC6}, {7'h00, br_seen});
      if (ofs != 8'hC8 && ofs != 8'hCA) chk("selected", {7'h00, l3}, {7'h00, selected});
      chk("irq", {7'h00, service_request}, {7'h00, irq});
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      #1 rst = 0;
      for (i = 0; i < 150; i++) begin
         seed = xorshift(seed);
         read_primary_data = seed[7:0];
         read_spare_data = seed[15:8];
         service_request = seed[16];
         if (seed[19:17] inside {3'h4, 3'h5, 3'h6}) begin
            for (k = 0; k < 3; k++)
               op({4'hC, 1'b1, k[1:0], 1'b0}, (seed[20 + k] && seed[23]) ? seed[31:24] : own[k]);
         end else
            op({4'hC, seed[19:17], 1'b0}, seed[31:24]);
      end
      give_verdict;
   end
endmodule // test_strobed_expansion_bus_slave
